// ### pkg/spft_pkg.sv
/*
  Constants shared by the serial control port and the fault timers.
  Assumes a single 100 MHz core clock and host-driven serial pins.
*/
// Behaviour
// - Serial input bit is captured on each serial clock rise while selected.
// - Next status bit is driven out on each serial clock fall.
// - With select high, clock and input are ignored and output floats.
// - Normal mode only with logic supply present; sleep when it goes.
// - Battery supply rising with logic supply present forces full reset.
// - Logic supply rising with battery supply present forces full reset.
// - Short filter programmable 30 to 960 us doubling, active while on.
// - Timers within 10 percent calibrated, 35 percent uncalibrated.
// - Pulse generator covers 10 Hz to 1.28 kHz.
// - Open-circuit fault filtered 100 to 400 us while outputs off.
// - After a short fault the gate on-time is limited to low duty.
// - Select fall enables output driver and loads status.
// - Select rise floats output and applies the received command.
// - Both words shift most significant bit first.
package spft_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int SHORT_BASE_US = 30;
  localparam int SHORT_STEPS = 6;
  localparam int OPEN_FILT_US = 200;
  localparam int DUTY_PERIOD_US = 1000;
  localparam int DUTY_ON_US = 10;
  localparam int RATE_BASE_HZ = 10;
  localparam int RATE_STEPS = 8;
  localparam int TRIM_SLOW = 135;
  localparam int TRIM_CAL = 100;
  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int CMD_OUT_LSB = 0;
  localparam int CMD_FILT_LSB = 4;
  localparam int CMD_RATE_LSB = 8;
  localparam int CMD_CAL_BIT = 11;
  localparam int CMD_PWM_BIT = 12;
  localparam logic [15:0] CMD_RESET = 16'h0000;
endpackage

// ### hdl/spft_timer.sv
/*
  Calibratable microsecond timebase.
  Assumes the core clock at the package rate; emits one-cycle ticks.
*/
module spft_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic calibrated,
  output logic tick
);
  localparam int SLOW = spft_pkg::TICK_CYC * spft_pkg::TRIM_SLOW / 100;
  localparam int FAST = spft_pkg::TICK_CYC * spft_pkg::TRIM_CAL / 100;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] lim;
  always_comb begin
    lim = calibrated ? 16'(FAST - 1) : 16'(SLOW - 1);
    nxt_cnt = (cnt_ff >= lim) ? 16'h0000 : cnt_ff + 16'h0001;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign tick = (cnt_ff == lim);
endmodule

// ### hdl/spft_port.sv
/*
  Serial command port with fault filter timers and pulse generator.
  Assumes host-driven select, clock and data pins and supply-present levels.
*/
module spft_port #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic battery_supply,
  input wire logic logic_supply,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so_o,
  output logic so_oe,
  input wire logic [3:0] short_in,
  input wire logic [3:0] open_in,
  output logic [3:0] gate_on,
  output logic [3:0] short_fault,
  output logic [3:0] open_fault,
  output logic sleep
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] cs_s, ck_s, si_s, vb_s, vl_s;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_s <= 3'h7;
      ck_s <= 3'h0;
      si_s <= 3'h0;
      vb_s <= 3'h0;
      vl_s <= 3'h0;
    end else begin
      cs_s <= {cs_s[1:0], cs_n};
      ck_s <= {ck_s[1:0], sclk};
      si_s <= {si_s[1:0], si};
      vb_s <= {vb_s[1:0], battery_supply};
      vl_s <= {vl_s[1:0], logic_supply};
    end
  end
  logic cs_lv_ff, ck_lv_ff, vb_lv_ff, vl_lv_ff;
  logic nxt_cs_lv, nxt_ck_lv, nxt_vb_lv, nxt_vl_lv;
  always_comb begin
    nxt_cs_lv = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_lv_ff;
    nxt_ck_lv = (ck_s[1] == ck_s[2]) ? ck_s[2] : ck_lv_ff;
    nxt_vb_lv = (vb_s[1] == vb_s[2]) ? vb_s[2] : vb_lv_ff;
    nxt_vl_lv = (vl_s[1] == vl_s[2]) ? vl_s[2] : vl_lv_ff;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_lv_ff <= 1'b1;
      ck_lv_ff <= 1'b0;
      vb_lv_ff <= 1'b0;
      vl_lv_ff <= 1'b0;
    end else begin
      cs_lv_ff <= nxt_cs_lv;
      ck_lv_ff <= nxt_ck_lv;
      vb_lv_ff <= nxt_vb_lv;
      vl_lv_ff <= nxt_vl_lv;
    end
  end
  logic cs_fall, cs_rise, ck_rise, ck_fall, por;
  always_comb begin
    cs_fall = cs_lv_ff & ~nxt_cs_lv;
    cs_rise = ~cs_lv_ff & nxt_cs_lv;
    ck_rise = ~ck_lv_ff & nxt_ck_lv & ~cs_lv_ff;
    ck_fall = ck_lv_ff & ~nxt_ck_lv & ~cs_lv_ff;
    por = (~vb_lv_ff & nxt_vb_lv & vl_lv_ff)
        | (~vl_lv_ff & nxt_vl_lv & vb_lv_ff)
        | ~vl_lv_ff;
  end
  // ------------------------------------------------------------
  // Shift path and command
  // ------------------------------------------------------------
  logic [WIDTH-1:0] rx_ff, tx_ff, cmd_ff, nxt_rx, nxt_tx, nxt_cmd;
  logic so_ff, oe_ff, nxt_so, nxt_oe;
  logic [3:0] sf_ff, of_ff;
  always_comb begin
    nxt_rx = rx_ff;
    nxt_tx = tx_ff;
    nxt_cmd = cmd_ff;
    nxt_so = so_ff;
    nxt_oe = oe_ff;
    if (por) begin
      nxt_cmd = WIDTH'(spft_pkg::CMD_RESET);
      nxt_oe = 1'b0;
    end else if (cs_fall) begin
      nxt_tx = {{(WIDTH - 8){1'b0}}, of_ff, sf_ff};
      nxt_so = nxt_tx[WIDTH-1];
      nxt_oe = 1'b1;
    end else if (cs_rise) begin
      nxt_oe = 1'b0;
      nxt_cmd = rx_ff;
    end else begin
      if (ck_rise) begin
        nxt_rx = {rx_ff[WIDTH-2:0], si_s[2]};
        nxt_tx = {tx_ff[WIDTH-2:0], 1'b0};
      end
      if (ck_fall) begin
        nxt_so = tx_ff[WIDTH-1];
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_ff <= '0;
      tx_ff <= '0;
      cmd_ff <= '0;
      so_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      rx_ff <= nxt_rx;
      tx_ff <= nxt_tx;
      cmd_ff <= nxt_cmd;
      so_ff <= nxt_so;
      oe_ff <= nxt_oe;
    end
  end
  // ------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------
  logic cal_ff, nxt_cal, tick;
  always_comb begin
    nxt_cal = cal_ff;
    if (por) begin
      nxt_cal = 1'b0;
    end else if (cs_rise && rx_ff[spft_pkg::CMD_CAL_BIT]) begin
      nxt_cal = 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cal_ff <= 1'b0;
    end else begin
      cal_ff <= nxt_cal;
    end
  end
  spft_timer u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .calibrated(cal_ff),
    .tick(tick)
  );
  // ------------------------------------------------------------
  // Pulse generator: period 1e6/(10*2^n) us
  // ------------------------------------------------------------
  function automatic logic [16:0] rate_period(input logic [2:0] n);
    rate_period = 17'((1000000 / spft_pkg::RATE_BASE_HZ) >> n);
  endfunction
  logic [16:0] pw_ff, nxt_pw;
  logic pwm;
  always_comb begin
    nxt_pw = pw_ff;
    if (tick) begin
      nxt_pw = (pw_ff + 17'h00001 >= rate_period(cmd_ff[spft_pkg::CMD_RATE_LSB +: 3]))
             ? 17'h00000 : pw_ff + 17'h00001;
    end
    pwm = (pw_ff < (rate_period(cmd_ff[spft_pkg::CMD_RATE_LSB +: 3]) >> 1));
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pw_ff <= '0;
    end else begin
      pw_ff <= nxt_pw;
    end
  end
  // ------------------------------------------------------------
  // Fault filters and faulted duty limit
  // ------------------------------------------------------------
  logic [10:0] sc_ff [4];
  logic [10:0] oc_ff [4];
  logic [10:0] nxt_sc [4];
  logic [10:0] nxt_oc [4];
  logic [9:0] dc_ff, nxt_dc;
  logic [3:0] nxt_sf, nxt_of, on_cmd, nxt_gate, gate_ff;
  logic [10:0] sc_lim;
  always_comb begin
    on_cmd = cmd_ff[spft_pkg::CMD_OUT_LSB +: 4] &
             (cmd_ff[spft_pkg::CMD_PWM_BIT] ? {4{pwm}} : 4'hF);
    sc_lim = 11'(spft_pkg::SHORT_BASE_US) << cmd_ff[spft_pkg::CMD_FILT_LSB +: 3];
    if (cmd_ff[spft_pkg::CMD_FILT_LSB +: 3] > 3'(spft_pkg::SHORT_STEPS - 1)) begin
      sc_lim = 11'(spft_pkg::SHORT_BASE_US) << (spft_pkg::SHORT_STEPS - 1);
    end
    nxt_dc = dc_ff;
    if (tick) begin
      nxt_dc = (dc_ff == 10'(spft_pkg::DUTY_PERIOD_US - 1)) ? 10'h000 : dc_ff + 10'h001;
    end
    // Reading status clears the flags, but a fault still present sets them again.
    nxt_sf = cs_fall ? 4'h0 : sf_ff;
    nxt_of = cs_fall ? 4'h0 : of_ff;
    for (int i = 0; i < 4; i++) begin
      nxt_sc[i] = sc_ff[i];
      nxt_oc[i] = oc_ff[i];
      if (!(on_cmd[i] && short_in[i])) begin
        nxt_sc[i] = '0;
      end else if (tick && sc_ff[i] < sc_lim) begin
        nxt_sc[i] = sc_ff[i] + 11'h001;
      end
      if (sc_ff[i] >= sc_lim && on_cmd[i] && short_in[i]) begin
        nxt_sf[i] = 1'b1;
      end
      if (on_cmd[i] || !open_in[i]) begin
        nxt_oc[i] = '0;
      end else if (tick && oc_ff[i] < 11'(spft_pkg::OPEN_FILT_US)) begin
        nxt_oc[i] = oc_ff[i] + 11'h001;
      end
      if (oc_ff[i] >= 11'(spft_pkg::OPEN_FILT_US) && !on_cmd[i] && open_in[i]) begin
        nxt_of[i] = 1'b1;
      end
      nxt_gate[i] = on_cmd[i] &
          (!sf_ff[i] || dc_ff < 10'(spft_pkg::DUTY_ON_US));
    end
    if (por) begin
      nxt_sf = '0;
      nxt_of = '0;
      nxt_gate = '0;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        sc_ff[i] <= '0;
        oc_ff[i] <= '0;
      end
      dc_ff <= '0;
      sf_ff <= '0;
      of_ff <= '0;
      gate_ff <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        sc_ff[i] <= nxt_sc[i];
        oc_ff[i] <= nxt_oc[i];
      end
      dc_ff <= nxt_dc;
      sf_ff <= nxt_sf;
      of_ff <= nxt_of;
      gate_ff <= nxt_gate;
    end
  end
  logic sleep_ff;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sleep_ff <= 1'b1;
    end else begin
      sleep_ff <= ~vl_lv_ff;
    end
  end
  assign so_o = so_ff;
  assign so_oe = oe_ff;
  assign gate_on = gate_ff;
  assign short_fault = sf_ff;
  assign open_fault = of_ff;
  assign sleep = sleep_ff;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_rise;
    cs_rise && !por;
  endsequence
  a_select_rise: assert property (@(posedge clock) disable iff (!rst_n)
    s_rise |=> !so_oe && cmd_ff == $past(rx_ff)) else $error("rise not applied");
  a_select_fall: assert property (@(posedge clock) disable iff (!rst_n)
    cs_fall && !por |=> so_oe) else $error("fall did not enable output");
  a_idle_float: assert property (@(posedge clock) disable iff (!rst_n)
    cs_lv_ff && $past(cs_lv_ff) && !$past(cs_fall) |-> !so_oe) else $error("output driven");
  a_shift_in: assert property (@(posedge clock) disable iff (!rst_n)
    ck_rise && !cs_rise && !cs_fall && !por |=> rx_ff[0] == $past(si_s[2]))
    else $error("bit not captured");
  a_shift_out: assert property (@(posedge clock) disable iff (!rst_n)
    ck_fall && !cs_fall && !cs_rise && !por |=> so_o == $past(tx_ff[WIDTH-1]))
    else $error("bit not driven");
  a_sleep_follow: assert property (@(posedge clock) disable iff (!rst_n)
    !vl_lv_ff |=> sleep) else $error("sleep missing");
  a_power_reset: assert property (@(posedge clock) disable iff (!rst_n)
    por |=> cmd_ff == '0 && !cal_ff ##1 gate_on == '0) else $error("reset incomplete");
  a_duty_limit: assert property (@(posedge clock) disable iff (!rst_n)
    sf_ff[0] && !por && dc_ff >= 10'(spft_pkg::DUTY_ON_US) |=> !gate_on[0])
    else $error("duty exceeded");
endmodule

// ### tb/spft_host.sv
/*
  Host model: serial bus master for the command port.
  Assumes the port samples its pins with its own faster clock.
*/
module spft_host (
  input wire logic so_o,
  input wire logic so_oe,
  output logic cs_n,
  output logic sclk,
  output logic si
);
  timeunit 1ns;
  timeprecision 100ps;
  logic so_last;
  logic so_line;
  // The line has no pull, so a released line shows the inverse of its last value.
  assign so_line = so_oe ? so_o : ~so_last;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    so_last = 1'b0;
  end
  // --------------------------------------------------------------
  // One frame, clock low at both select edges
  // --------------------------------------------------------------
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx,
                      output logic oe_seen);
    rx = '0;
    oe_seen = 1'b1;
    cs_n = 1'b0;
    #200;
    for (int i = nbits - 1; i >= 0; i--) begin
      si = tx[i];
      #62.5 sclk = 1'b1;
      rx = {rx[30:0], so_line};
      oe_seen = oe_seen & so_oe;
      so_last = so_line;
      #62.5 sclk = 1'b0;
    end
    si = ~si;
    #100 cs_n = 1'b1;
    #1000;
  endtask
  // --------------------------------------------------------------
  // Serial clock pulses with select held high
  // --------------------------------------------------------------
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      si = 1'b1;
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
  endtask
endmodule

// ### tb/serial_port_and_fault_timers_tb_top.sv
/*
  Self-checking bench for the serial command port and fault timers.
  Assumes the port's hand-over timing and a 100 MHz core clock.
*/
module serial_port_and_fault_timers_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic battery_supply = 1'b1;
  logic logic_supply = 1'b1;
  logic [3:0] short_in = 4'h0;
  logic [3:0] open_in = 4'h0;
  logic cs_n, sclk, si, so_o, so_oe, sleep, oe;
  logic [3:0] gate_on, short_fault, open_fault;
  logic [31:0] rx;
  int error_cnt = 0;
  int total_checks = 0;
  int c;
  always #5 clock = ~clock;
  spft_port u_dut (.clock(clock), .rst_n(rst_n), .battery_supply(battery_supply),
    .logic_supply(logic_supply), .cs_n(cs_n), .sclk(sclk), .si(si), .so_o(so_o),
    .so_oe(so_oe), .short_in(short_in), .open_in(open_in), .gate_on(gate_on),
    .short_fault(short_fault), .open_fault(open_fault), .sleep(sleep));
  spft_host u_host (.so_o(so_o), .so_oe(so_oe), .cs_n(cs_n), .sclk(sclk), .si(si));
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic send(input logic [31:0] w, input int n);
    u_host.xfer(w, n, rx, oe);
    repeat (8) @(posedge clock);
  endtask
  // Counts cycles until the chosen fault flag sets, giving up after 60000.
  task automatic time_fault(input bit sh, input int ch);
    c = 0;
    while (!((sh ? short_fault[ch] : open_fault[ch]) === 1'b1) && c < 60000) begin
      @(posedge clock);
      c++;
    end
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    check("sleep", sleep, 0);
    check("so_oe", so_oe, 0);
    check("gate", gate_on, 0);
    check("faults", {short_fault, open_fault}, 0);
  endtask
  task automatic t_command();
    send(32'h0005, 16);
    check("oe in frame", oe, 1);
    check("gate", gate_on, 4'h5);
    check("so_oe idle", so_oe, 0);
    u_host.idle_clocks(16);
    repeat (8) @(posedge clock);
    check("gate deselected", gate_on, 4'h5);
    check("so_oe deselected", so_oe, 0);
    send(32'hFF000A, 24);
    check("gate 24 bit", gate_on, 4'hA);
  endtask
  task automatic t_short();
    int on_cnt;
    on_cnt = 0;
    send(32'h0001, 16);
    @(posedge clock);
    short_in <= 4'h1;
    time_fault(1, 0);
    check("short uncal", c >= 1950 && c <= 4200, 1);
    repeat (20000) begin
      @(posedge clock);
      on_cnt += gate_on[0];
    end
    // Unlimited drive would stay on the whole window.
    check("short duty", on_cnt <= 1400, 1);
    short_in <= 4'h0;
    send(32'h0801, 16);
    @(posedge clock);
    short_in <= 4'h1;
    time_fault(1, 0);
    check("short cal", c >= 2700 && c <= 3400, 1);
    short_in <= 4'h0;
  endtask
  task automatic t_open();
    send(32'h0800, 16);
    @(posedge clock);
    // Channel three sets the low byte's top bit, so a bit sent out of order shows.
    open_in <= 4'h8;
    time_fault(0, 3);
    check("open filter", c >= 10000 && c <= 40000, 1);
    send(32'h0800, 16);
    check("status", rx[15:0], 32'h0080);
    open_in <= 4'h0;
  endtask
  task automatic t_supply();
    send(32'h0003, 16);
    check("gate", gate_on, 4'h3);
    logic_supply <= 1'b0;
    repeat (10) @(posedge clock);
    check("sleep", sleep, 1);
    check("gate sleep", gate_on, 0);
    logic_supply <= 1'b1;
    repeat (10) @(posedge clock);
    check("wake", sleep, 0);
    check("gate por", gate_on, 0);
    send(32'h0003, 16);
    check("gate before bat", gate_on, 4'h3);
    battery_supply <= 1'b0;
    repeat (10) @(posedge clock);
    battery_supply <= 1'b1;
    repeat (10) @(posedge clock);
    check("gate bat por", gate_on, 0);
  endtask
  // --------------------------------------------------------------
  // Sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    t_reset();
    t_command();
    t_short();
    t_open();
    t_supply();
    tally_and_finish();
  end
  // A full run is about half a millisecond; the limit stays under 100000 cycles.
  initial begin
    #900000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
